// ===== logic/awr_pkg.sv
// Purpose: shared constants and types for the converter result and window register block
// Assumes: byte-wide registers on a 32-bit avalon-mm word bus, one register byte per word
// Notes:   offsets below are byte indices; bus byte address is four times the index
//
// Function
// - the result is a read-only 16-bit value split into a high byte 15:8 and a low byte 7:0, both zero after reset.
// - a single conversion places its 10-bit code in result bits 9:0 with the top bit at bit 9.
// - result and accumulated values are unsigned, all zeros meaning zero and all ones meaning full scale.
// - a read/write 16-bit low threshold, reset to zero, feeds the window comparator on the result.
// - a read/write 16-bit high threshold, reset to zero, feeds the same window comparator.
// - each threshold is two bytes, low byte at the base offset and high byte at base plus one.
// - while accumulating, the comparator sees only the final accumulated value, never single samples.
// - the duty select bit at bit 0 resets to 1, giving a 25 percent high converter clock for 1.5 MHz or less.
// - conversions saturate at 0x3FF (only the upper end is clamped), so totals never pass 0xFFC0 after 64 accumulations.
// - 16-bit accesses pass through one shared temporary byte so both halves are consistent.

`default_nettype none

package awr_pkg;

  // ***************************************************************
  // register byte indices
  // ***************************************************************
  localparam logic [7:0] TEMP_IDX   = 8'h0D;
  localparam logic [7:0] RESULT_IDX = 8'h10;
  localparam logic [7:0] WINLO_IDX  = 8'h12;
  localparam logic [7:0] WINHI_IDX  = 8'h14;
  localparam logic [7:0] CLKCAL_IDX = 8'h16;
  localparam logic [7:0] HIGH_BYTE  = 8'h01;

  // ***************************************************************
  // reset values and fields
  // ***************************************************************
  localparam logic [15:0] RESULT_RST = 16'h0000;
  localparam logic [15:0] WIN_RST    = 16'h0000;
  localparam logic [7:0]  TEMP_RST   = 8'h00;
  localparam logic [2:0]  CLKCAL_RST = 3'h1;
  localparam int          DUTY_BIT   = 0;
  localparam logic [9:0]  CODE_MAX   = 10'h3FF;
  localparam logic [15:0] ACC_MAX    = 16'hFFC0;
  localparam logic [6:0]  ACC_LIMIT  = 7'h40;

  // ***************************************************************
  // carriers
  // ***************************************************************
  typedef struct packed {
    logic        valid;
    logic        last;
    logic [11:0] code;
  } awr_sample_s;

  typedef struct packed {
    logic [15:0] low;
    logic [15:0] high;
  } awr_window_s;

endpackage : awr_pkg

`default_nettype wire

// ===== logic/awr_regs.sv
// Purpose: result, window threshold and calibration registers of the converter
// Assumes: samples arrive in the clk_in domain; at most 64 samples per accumulation
// Notes:   avalon-mm slave with one wait state on every access
//
// The Avalon-MM register port is this design's own decision.

`timescale 1ns/10ps
`default_nettype none

module awr_regs (
  // clock and reset
  input  wire logic                clk_in,
  input  wire logic                rst_b_in,
  // avalon-mm slave
  input  wire logic [9:0]          avs_address_in,
  input  wire logic                avs_read_in,
  input  wire logic                avs_write_in,
  input  wire logic [31:0]         avs_writedata_in,
  input  wire logic [3:0]          avs_byteenable_in,
  output logic      [31:0]         avs_readdata_out,
  output logic                     avs_waitrequest_out,
  output logic      [1:0]          avs_response_out,
  // converter sample stream
  input  wire awr_pkg::awr_sample_s sample_in,
  // toward comparator and clock generator
  output var awr_pkg::awr_window_s window_out,
  output logic      [15:0]         conversion_result_out,
  output logic                     result_valid_out,
  output logic                     adc_clock_duty_select_out
);

  // ***************************************************************
  // saturation
  // ***************************************************************
  function automatic logic [9:0] sat_code(input logic [11:0] raw);
    sat_code = (raw > {2'h0, awr_pkg::CODE_MAX}) ? awr_pkg::CODE_MAX : raw[9:0];
  endfunction

  // ***************************************************************
  // bus handshake: one wait state so read data come from flops
  // ***************************************************************
  logic        ack_q;
  logic        req;
  logic [7:0]  idx;
  logic        wr_hit;
  logic        rd_hit;

  assign req    = avs_read_in | avs_write_in;
  assign idx    = avs_address_in[9:2];
  assign wr_hit = avs_write_in & ack_q & avs_byteenable_in[0];
  assign rd_hit = avs_read_in & ack_q;
  assign avs_waitrequest_out = req & ~ack_q;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == awr_pkg::TEMP_IDX) || (a == awr_pkg::RESULT_IDX) ||
             (a == awr_pkg::RESULT_IDX + awr_pkg::HIGH_BYTE) ||
             (a == awr_pkg::WINLO_IDX) || (a == awr_pkg::WINLO_IDX + awr_pkg::HIGH_BYTE) ||
             (a == awr_pkg::WINHI_IDX) || (a == awr_pkg::WINHI_IDX + awr_pkg::HIGH_BYTE) ||
             (a == awr_pkg::CLKCAL_IDX);
  endfunction

  // ***************************************************************
  // accumulation
  // ***************************************************************
  logic [15:0] acc_q;
  logic [15:0] result_q;
  logic        result_valid_q;
  logic [15:0] acc_sum;
  logic [6:0]  acc_cnt_q;

  // a sample is clamped before it enters the sum, so 64 of them cannot overflow
  assign acc_sum = acc_q + {6'h00, sat_code(sample_in.code)};

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      acc_q <= awr_pkg::RESULT_RST;
    end else if (sample_in.valid) begin
      acc_q <= sample_in.last ? awr_pkg::RESULT_RST : acc_sum;
    end
  end

  // samples already summed; only the checks read it, the datapath trusts the producer
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      acc_cnt_q <= 7'h00;
    end else if (sample_in.valid) begin
      acc_cnt_q <= sample_in.last ? 7'h00 : acc_cnt_q + 7'h01;
    end
  end

  // only the final total is published, so the window never sees partial sums
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      result_q       <= awr_pkg::RESULT_RST;
      result_valid_q <= 1'b0;
    end else begin
      result_valid_q <= sample_in.valid & sample_in.last;
      if (sample_in.valid && sample_in.last) begin
        result_q <= acc_sum;
      end
    end
  end

  assign conversion_result_out = result_q;
  assign result_valid_out      = result_valid_q;

  // ***************************************************************
  // shared temporary byte and threshold registers
  // ***************************************************************
  logic [7:0]  temp_q;
  logic [15:0] win_lo_q;
  logic [15:0] win_hi_q;
  logic [2:0]  clkcal_q;
  logic [7:0]  wbyte;

  assign wbyte = avs_writedata_in[7:0];

  // low byte read latches the high half; low byte write parks in temp
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      temp_q <= awr_pkg::TEMP_RST;
    end else if (wr_hit && (idx == awr_pkg::TEMP_IDX || idx == awr_pkg::WINLO_IDX
                            || idx == awr_pkg::WINHI_IDX)) begin
      temp_q <= wbyte;
    end else if (rd_hit) begin
      case (idx)
        awr_pkg::RESULT_IDX: temp_q <= result_q[15:8];
        awr_pkg::WINLO_IDX: temp_q <= win_lo_q[15:8];
        awr_pkg::WINHI_IDX: temp_q <= win_hi_q[15:8];
        default:            temp_q <= temp_q;
      endcase
    end
  end

  // high byte write commits both halves at once
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      win_lo_q <= awr_pkg::WIN_RST;
    end else if (wr_hit && idx == awr_pkg::WINLO_IDX + awr_pkg::HIGH_BYTE) begin
      win_lo_q <= {wbyte, temp_q};
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      win_hi_q <= awr_pkg::WIN_RST;
    end else if (wr_hit && idx == awr_pkg::WINHI_IDX + awr_pkg::HIGH_BYTE) begin
      win_hi_q <= {wbyte, temp_q};
    end
  end

  // bits 2:1 are plain storage; bit 0 drives the converter clock duty
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      clkcal_q <= awr_pkg::CLKCAL_RST;
    end else if (wr_hit && idx == awr_pkg::CLKCAL_IDX) begin
      clkcal_q <= wbyte[2:0];
    end
  end

  assign window_out.low            = win_lo_q;
  assign window_out.high           = win_hi_q;
  assign adc_clock_duty_select_out = clkcal_q[awr_pkg::DUTY_BIT];

  // ***************************************************************
  // read data and response
  // ***************************************************************
  logic [7:0] rbyte;

  always_comb begin
    case (idx)
      awr_pkg::TEMP_IDX:                       rbyte = temp_q;
      awr_pkg::RESULT_IDX:                     rbyte = result_q[7:0];
      awr_pkg::RESULT_IDX + awr_pkg::HIGH_BYTE: rbyte = temp_q;
      awr_pkg::WINLO_IDX:                      rbyte = win_lo_q[7:0];
      awr_pkg::WINLO_IDX + awr_pkg::HIGH_BYTE: rbyte = temp_q;
      awr_pkg::WINHI_IDX:                      rbyte = win_hi_q[7:0];
      awr_pkg::WINHI_IDX + awr_pkg::HIGH_BYTE: rbyte = temp_q;
      awr_pkg::CLKCAL_IDX:                     rbyte = {5'h00, clkcal_q};
      default:                                 rbyte = 8'h00;
    endcase
  end

  logic [31:0] rdata_q;
  logic [1:0]  resp_q;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata_q <= 32'h0000_0000;
      resp_q  <= 2'h0;
    end else begin
      rdata_q <= (avs_read_in && !ack_q) ? {24'h000000, rbyte} : rdata_q;
      resp_q  <= (req && !ack_q) ? (mapped(idx) ? 2'h0 : 2'h2) : resp_q;
    end
  end

  assign avs_readdata_out = rdata_q;
  assign avs_response_out = resp_q;

  // ***************************************************************
  // checks
  // ***************************************************************
  AST_RESULT_RO: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    !(sample_in.valid && sample_in.last) |=> $stable(result_q))
    else $error("result changed without a final sample");

  AST_CODE_SAT: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (sample_in.valid && sample_in.last && acc_q == awr_pkg::RESULT_RST) |=> result_q <= {6'h00, awr_pkg::CODE_MAX})
    else $error("single conversion exceeded ten bits");

  AST_RESULT_TOTAL: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (sample_in.valid && sample_in.last) |=> result_q == $past(acc_sum))
    else $error("result does not hold the final total");

  AST_FINAL_ONLY: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (sample_in.valid && !sample_in.last) |=> !result_valid_out)
    else $error("partial sum offered to window");

  AST_WINLO_COMMIT: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (wr_hit && idx == awr_pkg::WINLO_IDX + awr_pkg::HIGH_BYTE) |=> win_lo_q == {$past(wbyte), $past(temp_q)})
    else $error("low threshold commit wrong");

  AST_WINHI_COMMIT: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (wr_hit && idx == awr_pkg::WINHI_IDX + awr_pkg::HIGH_BYTE) |=> win_hi_q == {$past(wbyte), $past(temp_q)})
    else $error("high threshold commit wrong");

  AST_LOW_BYTE_HOLD: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (wr_hit && idx == awr_pkg::WINLO_IDX) |=> ($stable(win_lo_q) && temp_q == $past(wbyte)))
    else $error("low byte write touched threshold");

  AST_RESULT_LATCH: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (rd_hit && idx == awr_pkg::RESULT_IDX) |=> temp_q == $past(result_q[15:8]))
    else $error("result high half not latched");

  AST_DUTY: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (wr_hit && idx == awr_pkg::CLKCAL_IDX) |=> adc_clock_duty_select_out == $past(wbyte[0]))
    else $error("duty select not written");

  AST_WAIT: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    ($rose(req) && !ack_q) |-> avs_waitrequest_out ##1 !avs_waitrequest_out)
    else $error("waitrequest timing wrong");

  AST_ACC_BOUND: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (acc_cnt_q < awr_pkg::ACC_LIMIT)
    |-> (acc_q <= awr_pkg::ACC_MAX))
    else $error("running sum passed the accumulation ceiling");

  AST_RESULT_BOUND: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (sample_in.valid && sample_in.last && acc_cnt_q < awr_pkg::ACC_LIMIT)
    |=> (result_q <= awr_pkg::ACC_MAX))
    else $error("published total passed the accumulation ceiling");

  AST_ACC_ADD: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (sample_in.valid && !sample_in.last && sample_in.code <= {2'h0, awr_pkg::CODE_MAX})
    |=> (acc_q == $past(acc_q) + {4'h0, $past(sample_in.code)}))
    else $error("in-range sample not added unchanged");

  AST_ACC_SAT: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (sample_in.valid && !sample_in.last && sample_in.code > {2'h0, awr_pkg::CODE_MAX})
    |=> (acc_q == $past(acc_q) + {6'h00, awr_pkg::CODE_MAX}))
    else $error("out-of-range sample not clamped");

  AST_ACC_RESTART: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (sample_in.valid && sample_in.last)
    |=> (acc_q == awr_pkg::RESULT_RST))
    else $error("sum not restarted after final sample");

  AST_ACC_IDLE: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    !sample_in.valid
    |=> $stable(acc_q))
    else $error("sum moved without a sample");

  AST_VALID_AFTER_LAST: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (sample_in.valid && sample_in.last)
    |=> result_valid_out)
    else $error("final total not offered to window");

  AST_WINLO_HOLD: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    !(wr_hit && idx == awr_pkg::WINLO_IDX + awr_pkg::HIGH_BYTE)
    |=> $stable(window_out.low))
    else $error("low threshold moved without a commit");

  AST_WINHI_HOLD: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    !(wr_hit && idx == awr_pkg::WINHI_IDX + awr_pkg::HIGH_BYTE)
    |=> $stable(window_out.high))
    else $error("high threshold moved without a commit");

  AST_WINHI_LOW_BYTE_HOLD: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (wr_hit && idx == awr_pkg::WINHI_IDX)
    |=> ($stable(win_hi_q) && temp_q == $past(wbyte)))
    else $error("high threshold low byte write touched threshold");

  AST_WINLO_LATCH: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (rd_hit && idx == awr_pkg::WINLO_IDX)
    |=> (temp_q == $past(win_lo_q[15:8])))
    else $error("low threshold high half not latched");

  AST_WINHI_LATCH: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (rd_hit && idx == awr_pkg::WINHI_IDX)
    |=> (temp_q == $past(win_hi_q[15:8])))
    else $error("high threshold high half not latched");

  AST_RESULT_HIGH_READ: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (avs_read_in && !ack_q && idx == awr_pkg::RESULT_IDX + awr_pkg::HIGH_BYTE)
    |=> (avs_readdata_out == {24'h000000, $past(temp_q)}))
    else $error("result high byte not served from temp");

  AST_TEMP_READ: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (avs_read_in && !ack_q && idx == awr_pkg::TEMP_IDX)
    |=> (avs_readdata_out == {24'h000000, $past(temp_q)}))
    else $error("temp read data wrong");

  AST_RESULT_LOW_READ: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (avs_read_in && !ack_q && idx == awr_pkg::RESULT_IDX)
    |=> (avs_readdata_out == {24'h000000, $past(result_q[7:0])}))
    else $error("result low byte read data wrong");

  AST_CLKCAL_READ: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (avs_read_in && !ack_q && idx == awr_pkg::CLKCAL_IDX)
    |=> (avs_readdata_out[7:3] == 5'h00 && avs_readdata_out[0] == $past(adc_clock_duty_select_out)))
    else $error("calibration read data wrong");

  AST_DUTY_HOLD: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    !(wr_hit && idx == awr_pkg::CLKCAL_IDX)
    |=> $stable(adc_clock_duty_select_out))
    else $error("duty select moved without a write");

  AST_NO_LANE: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (avs_write_in && !avs_byteenable_in[0])
    |=> ($stable(win_lo_q) && $stable(win_hi_q) && $stable(temp_q) && $stable(clkcal_q)))
    else $error("write without byte lane changed a register");

  AST_RDATA_UPPER: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (avs_read_in && ack_q)
    |-> (avs_readdata_out[31:8] == 24'h000000))
    else $error("upper read data bits not zero");

endmodule // awr_regs

`default_nettype wire

// ===== testbench/tb_top.sv
// Purpose: self-checking bench for the result, window threshold and calibration registers
// Assumes: avalon-mm master that waits for waitrequest low; byte address is four times the index
// Notes:   16-bit reads go low byte first, since the high byte comes from the shared temp
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  // ***************************************************************
  // signals
  // ***************************************************************
  logic                 clk_in;
  logic                 rst_b_in;
  logic [9:0]           adr;
  logic                 rd_r;
  logic                 wr_r;
  logic [31:0]          wdat;
  logic [3:0]           be_r;
  logic [31:0]          rdat;
  logic                 wreq;
  logic [1:0]           rsp;
  awr_pkg::awr_sample_s smp;
  awr_pkg::awr_window_s win;
  logic [15:0]          result;
  logic                 rvalid;
  logic                 duty;
  int                   mismatches = 0;
  int                   checks = 0;
  int                   pulses = 0;
  logic [7:0]           rb;
  logic [1:0]           rr;
  logic [15:0]          w16;

  awr_regs u_awr_regs (
    .clk_in                    (clk_in),
    .rst_b_in                  (rst_b_in),
    .avs_address_in            (adr),
    .avs_read_in               (rd_r),
    .avs_write_in              (wr_r),
    .avs_writedata_in          (wdat),
    .avs_byteenable_in         (be_r),
    .avs_readdata_out          (rdat),
    .avs_waitrequest_out       (wreq),
    .avs_response_out          (rsp),
    .sample_in                 (smp),
    .window_out                (win),
    .conversion_result_out     (result),
    .result_valid_out          (rvalid),
    .adc_clock_duty_select_out (duty)
  );

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  always @(posedge clk_in) begin
    if (rvalid === 1'b1) pulses <= pulses + 1;
  end

  // ***************************************************************
  // tasks
  // ***************************************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // request held until the edge that sees waitrequest low; data taken at that edge; a hang is left to the watchdog
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    logic ok;
    ok = 1'b0;
    @(posedge clk_in);
    adr  <= {idx, 2'h0};
    rd_r <= ~w;
    wr_r <= w;
    wdat <= {24'h000000, d};
    while (!ok) begin
      @(posedge clk_in);
      ok = (wreq === 1'b0);
    end
    rb = rdat[7:0];
    rr = rsp;
    rd_r <= 1'b0;
    wr_r <= 1'b0;
  endtask

  task automatic wr16(input logic [7:0] idx, input logic [15:0] v);
    bus(1'b1, idx, v[7:0]);
    bus(1'b1, idx + awr_pkg::HIGH_BYTE, v[15:8]);
  endtask

  task automatic rd16(input logic [7:0] idx, output logic [15:0] v);
    bus(1'b0, idx, 8'h00);
    v[7:0] = rb;
    bus(1'b0, idx + awr_pkg::HIGH_BYTE, 8'h00);
    v[15:8] = rb;
  endtask

  // back-to-back samples, last flagged on the final one
  task automatic conv(input int cnt, input logic [11:0] code);
    for (int i = 0; i < cnt; i++) begin
      @(posedge clk_in);
      smp <= {1'b1, (i == cnt - 1), code};
    end
    @(posedge clk_in);
    smp <= '0;
    repeat (3) @(posedge clk_in);
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ***************************************************************
  // tests
  // ***************************************************************
  initial begin
    rst_b_in = 1'b0;
    adr = 10'h000;
    rd_r = 1'b0;
    wr_r = 1'b0;
    wdat = 32'h00000000;
    be_r = 4'hF;
    smp = '0;
    repeat (12) @(posedge clk_in);
    rst_b_in <= 1'b1;
    chk({15'h0000, duty}, 16'h0001, "duty at reset");
    rd16(awr_pkg::RESULT_IDX, w16);
    chk(w16, 16'h0000, "result at reset");
    rd16(awr_pkg::WINLO_IDX, w16);
    chk(w16, 16'h0000, "low threshold at reset");
    rd16(awr_pkg::WINHI_IDX, w16);
    chk(w16, 16'h0000, "high threshold at reset");
    bus(1'b0, awr_pkg::CLKCAL_IDX, 8'h00);
    chk({8'h00, rb}, 16'h0001, "clock calibration at reset");
    $display("test reset values done");
    wr16(awr_pkg::WINLO_IDX, 16'hAB34);
    wr16(awr_pkg::WINHI_IDX, 16'h12CD);
    bus(1'b0, awr_pkg::TEMP_IDX, 8'h00);
    chk({8'h00, rb}, 16'h00CD, "shared temp after low byte write");
    rd16(awr_pkg::WINLO_IDX, w16);
    chk(w16, 16'hAB34, "low threshold readback");
    chk(win.low, 16'hAB34, "low threshold to comparator");
    rd16(awr_pkg::WINHI_IDX, w16);
    chk(w16, 16'h12CD, "high threshold readback");
    chk(win.high, 16'h12CD, "high threshold to comparator");
    be_r <= 4'h0;
    wr16(awr_pkg::WINLO_IDX, 16'h5555);
    be_r <= 4'hF;
    rd16(awr_pkg::WINLO_IDX, w16);
    chk(w16, 16'hAB34, "disabled byte lane write");
    bus(1'b0, 8'h20, 8'h00);
    chk({14'h0000, rr}, 16'h0002, "unmapped response");
    chk({8'h00, rb}, 16'h0000, "unmapped data");
    $display("test thresholds done");
    bus(1'b1, awr_pkg::CLKCAL_IDX, 8'h06);
    bus(1'b0, awr_pkg::CLKCAL_IDX, 8'h00);
    chk({8'h00, rb}, 16'h0006, "clock calibration readback");
    chk({15'h0000, duty}, 16'h0000, "duty cleared");
    bus(1'b1, awr_pkg::CLKCAL_IDX, 8'h01);
    bus(1'b0, awr_pkg::CLKCAL_IDX, 8'h00);
    chk({15'h0000, duty}, 16'h0001, "duty set");
    $display("test calibration done");
    conv(1, 12'h2A5);
    rd16(awr_pkg::RESULT_IDX, w16);
    chk(w16, 16'h02A5, "single conversion");
    conv(1, 12'hFFF);
    rd16(awr_pkg::RESULT_IDX, w16);
    chk(w16, 16'h03FF, "saturated conversion");
    conv(64, 12'hFFF);
    rd16(awr_pkg::RESULT_IDX, w16);
    chk(w16, 16'hFFC0, "full accumulation");
    conv(4, 12'h100);
    rd16(awr_pkg::RESULT_IDX, w16);
    chk(w16, 16'h0400, "restart after last");
    chk(pulses[15:0], 16'h0004, "one result per accumulation");
    $display("test conversions done");
    test_done();
  end

  // a hang cuts the run short well beyond the expected length
  initial begin
    repeat (5000) @(posedge clk_in);
    mismatches++;
    $display("ERROR t=%0t watchdog expired", $time);
    test_done();
  end
endmodule // tb_top

`default_nettype wire
